// File: control_sequencer_and_address_regs_tb.sv
// Self-checking testbench for the control sequencer
`timescale 1ns/1ps
`include "csq_consts.svh"
module control_sequencer_and_address_regs_tb;
  typedef struct packed {logic [3:0] seq; logic [15:0] addr; logic wr;} csq_row_t;
  logic        clk, arst_n, run, intr_req, buf_req, io_req, io_dbl, io_write, parity_clr;
  logic        acc_zero, acc_neg, add_sign_a, add_sign_b, add_sign_r, add_step;
  logic [2:0]  buf_chan, index_select_reg;
  logic [15:0] io_addr, main_mem_addr_reg, pc_reg, b_hold_reg;
  logic [17:0] mem_rd_data, adder_in;
  logic [7:0]  ctl_mem_addr_reg;
  logic        mem_start_reg, ctl_mem_sel_reg, mem_write_reg, xfer_en_reg, shift_en_reg;
  logic        parity_err_reg, jump_en_reg, ovf_reg;
  logic [1:0]  phase_reg, clk_cycle_reg;
  logic [3:0]  seq_code_reg;
  logic [4:0]  page_extension_reg;
  logic [5:0]  count_reg;
  int          fails, check_count, cycles, shift_pulses, n;
  csq_row_t    rows [15];

  csq_sequencer #(.PHASE_CYC(1)) dut_u (.clk, .arst_n, .run, .intr_req, .buf_req, .buf_chan, .io_req,
    .io_dbl, .io_write, .io_addr, .mem_rd_data, .adder_in, .parity_clr, .acc_zero, .acc_neg, .add_sign_a,
    .add_sign_b, .add_sign_r, .add_step, .main_mem_addr_reg, .ctl_mem_addr_reg, .mem_start_reg,
    .ctl_mem_sel_reg, .mem_write_reg, .phase_reg, .clk_cycle_reg, .seq_code_reg, .pc_reg, .index_select_reg,
    .page_extension_reg, .count_reg, .b_hold_reg, .xfer_en_reg, .shift_en_reg, .parity_err_reg,
    .jump_en_reg, .ovf_reg);
  // Slow answer: ten cycles of a sixteen-cycle computer cycle
  csq_mem_model #(.LAT(10)) mem_u (.clk, .main_mem_addr_reg, .mem_start_reg, .ctl_mem_sel_reg, .mem_rd_data);

  initial clk = 1'b0;
  always #5 clk = ~clk;
  always @(posedge clk) if (shift_en_reg === 1'b1) shift_pulses++;
  // Whole run needs well under 1500 cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      fails++;
      print_verdict();
    end
  end

  task automatic check(input string name, input logic [17:0] seen, input logic [17:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic wait_start();
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (mem_start_reg !== 1'b1 && n < 400);
    if (n >= 400) check("mem_start_reg", 18'(mem_start_reg), 18'h00001);
  endtask

  task automatic print_verdict();
    $display("Checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial begin
    {arst_n, intr_req, buf_req, io_req, io_dbl, io_write, parity_clr, acc_zero, acc_neg} = 9'h000;
    {add_sign_a, add_sign_b, add_sign_r, add_step} = 4'h0;
    run = 1'b1;
    buf_chan = 3'h0;
    io_addr = 16'h0000;
    adder_in = 18'h00001;
    rows = '{'{4'h1, 16'h0000, 1'b0}, '{4'h1, 16'h0001, 1'b0}, '{4'h1, 16'h0002, 1'b0},
             '{4'h1, 16'h0003, 1'b0}, '{4'h2, 16'h0120, 1'b0}, '{4'h1, 16'h0004, 1'b0},
             '{4'h2, 16'h0200, 1'b0}, '{4'h3, 16'h0201, 1'b0}, '{4'h1, 16'h0005, 1'b0},
             '{4'h4, 16'h0300, 1'b1}, '{4'h1, 16'h0006, 1'b0}, '{4'h1, 16'h0007, 1'b0},
             '{4'h2, 16'hA030, 1'b0}, '{4'h1, 16'h0008, 1'b0}, '{4'h1, 16'h0009, 1'b0}};
    repeat (10) @(negedge clk);
    mem_u.mem_arr[0] = {`CSQ_FN_LD_SEL, 12'h005};
    mem_u.mem_arr[1] = {`CSQ_FN_LD_IDX, 12'h020};
    mem_u.mem_arr[2] = {`CSQ_FN_LD_PAGE, 12'h00A};
    mem_u.mem_arr[3] = {6'h09, 12'h100};
    mem_u.mem_arr[4] = {6'h18, 12'h200};
    mem_u.mem_arr[5] = {6'h20, 12'h300};
    mem_u.mem_arr[6] = {`CSQ_FN_LD_SKIP, 12'h008};
    mem_u.mem_arr[7] = {6'h0B, 12'h010};
    mem_u.mem_arr[8] = {6'h02, 12'h003};
    mem_u.mem_arr[9] = {`CSQ_FN_WAIT, 12'h000};
    mem_u.mem_arr[10] = {6'h30, 12'h000};
    check("pc_reg", 18'(pc_reg), 18'h00000);
    check("seq_code_reg", 18'(seq_code_reg), 18'h00000);
    check("count_reg", 18'(count_reg), 18'h00000);
    arst_n = 1'b1;
    $display("Test reset done");
    // Two ones is even parity, three is odd
    adder_in = 18'h00003;
    add_sign_r = 1'b1;
    add_step = 1'b1;
    @(negedge clk) add_step = 1'b0;
    @(negedge clk) check("parity_err_reg", 18'(parity_err_reg), 18'h00001);
    check("ovf_reg", 18'(ovf_reg), 18'h00001);
    parity_clr = 1'b1;
    @(negedge clk) parity_clr = 1'b0;
    adder_in = 18'h00007;
    add_sign_r = 1'b0;
    add_step = 1'b1;
    @(negedge clk) add_step = 1'b0;
    @(negedge clk) check("parity_err_reg", 18'(parity_err_reg), 18'h00000);
    check("ovf_reg", 18'(ovf_reg), 18'h00000);
    $display("Test parity done");
    foreach (rows[i]) begin
      wait_start();
      check("seq_code_reg", 18'(seq_code_reg), 18'(rows[i].seq));
      check("main_mem_addr_reg", 18'(main_mem_addr_reg), 18'(rows[i].addr));
      check("mem_write_reg", 18'(mem_write_reg), 18'(rows[i].wr));
      check("clk_cycle_reg", 18'({clk_cycle_reg, phase_reg}), 18'h00000);
    end
    // The three-step shift runs on past the boundary
    repeat (8) @(negedge clk);
    check("shift_pulses", 18'(shift_pulses), 18'h00003);
    check("count_reg", 18'(count_reg), 18'h00000);
    check("index_select_reg", 18'(index_select_reg), 18'h00005);
    check("page_extension_reg", 18'(page_extension_reg), 18'h0000A);
    check("b_hold_reg", 18'(b_hold_reg), 18'h00020);
    $display("Test program done");
    n = 0;
    while (seq_code_reg !== 4'hA && n < 100) begin
      @(negedge clk);
      n++;
    end
    check("seq_code_reg", 18'(seq_code_reg), 18'h0000A);
    buf_req = 1'b1;
    buf_chan = 3'h3;
    wait_start();
    buf_req = 1'b0;
    check("seq_code_reg", 18'(seq_code_reg), 18'h00006);
    check("ctl_mem_addr_reg", 18'(ctl_mem_addr_reg), 18'h00016);
    check("ctl_mem_sel_reg", 18'(ctl_mem_sel_reg), 18'h00001);
    wait_start();
    check("seq_code_reg", 18'(seq_code_reg), 18'h00007);
    check("ctl_mem_addr_reg", 18'(ctl_mem_addr_reg), 18'h00017);
    {io_req, io_dbl, io_write} = 3'h7;
    io_addr = 16'h1234;
    wait_start();
    io_req = 1'b0;
    check("seq_code_reg", 18'(seq_code_reg), 18'h00008);
    check("main_mem_addr_reg", 18'(main_mem_addr_reg), 18'h01234);
    check("mem_write_reg", 18'(mem_write_reg), 18'h00001);
    wait_start();
    check("seq_code_reg", 18'(seq_code_reg), 18'h00009);
    check("main_mem_addr_reg", 18'(main_mem_addr_reg), 18'h01235);
    repeat (40) @(negedge clk);
    check("seq_code_reg", 18'(seq_code_reg), 18'h0000A);
    intr_req = 1'b1;
    wait_start();
    intr_req = 1'b0;
    check("seq_code_reg", 18'(seq_code_reg), 18'h00005);
    check("ctl_mem_addr_reg", 18'(ctl_mem_addr_reg), 18'h00040);
    $display("Test wait and io done");
    acc_zero = 1'b1;
    wait_start();
    check("seq_code_reg", 18'(seq_code_reg), 18'h00001);
    check("main_mem_addr_reg", 18'(main_mem_addr_reg), 18'h0000A);
    repeat (12) @(negedge clk);
    check("xfer_en_reg", 18'(xfer_en_reg), 18'h00001);
    wait_start();
    check("jump_en_reg", 18'(jump_en_reg), 18'h00001);
    check("main_mem_addr_reg", 18'(main_mem_addr_reg), 18'h0000B);
    check("addr_moves", 18'(mem_u.addr_moves), 18'h00000);
    $display("Test jump done");
    arst_n = 1'b0;
    @(negedge clk) check("pc_reg", 18'(pc_reg), 18'h00000);
    check("main_mem_addr_reg", 18'(main_mem_addr_reg), 18'h00000);
    arst_n = 1'b1;
    repeat (2) @(negedge clk);
    check("seq_code_reg", 18'(seq_code_reg), 18'h00000);
    $display("Test mid-run reset done");
    print_verdict();
  end
endmodule

// File: csq_consts.svh
// Constants for the control sequencer: timing, function codes, addresses
`ifndef CSQ_CONSTS_SVH
`define CSQ_CONSTS_SVH
`define CSQ_CLK_NS        10
`define CSQ_CYCLE_NS      500
`define CSQ_PHASES        4
`define CSQ_PHASE_NS      (`CSQ_CYCLE_NS / `CSQ_PHASES)
`define CSQ_PHASE_CYC     (`CSQ_PHASE_NS / `CSQ_CLK_NS)
`define CSQ_FN_IDX_LO     6'h03
`define CSQ_FN_IDX_HI     6'h27
`define CSQ_FN_WAIT       6'h3F
`define CSQ_FN_LD_SEL     6'h3E
`define CSQ_FN_LD_PAGE    6'h3D
`define CSQ_FN_LD_SKIP    6'h3C
`define CSQ_FN_LD_IDX     6'h3B
`define CSQ_K_PAGE_BIT    3
`define CSQ_CTL_INTR_ADDR 8'h40
`define CSQ_CTL_BUF_BASE  8'h10
`endif

// File: csq_mem_model.sv
// Behavioural main memory that answers the sequencer's read cycles
`timescale 1ns/1ps
module csq_mem_model #(
  parameter int LAT = 3
) (
  // Clock
  input  wire logic        clk,
  // Address side
  input  wire logic [15:0] main_mem_addr_reg,
  input  wire logic        mem_start_reg,
  input  wire logic        ctl_mem_sel_reg,
  // Read data
  output logic [17:0]      mem_rd_data
);
  logic [17:0] mem_arr [0:63];
  logic [15:0] addr_q;
  int          wait_cnt;
  int          addr_moves;
  initial begin
    mem_rd_data = 18'h2AAAA;
    wait_cnt = 0;
    addr_moves = 0;
    addr_q = 16'h0000;
  end
  // Address is taken at cycle start and must not move until the access ends
  always @(posedge clk) begin
    if (mem_start_reg === 1'b1 && ctl_mem_sel_reg === 1'b0) begin
      addr_q <= main_mem_addr_reg;
      wait_cnt <= LAT;
    end else if (wait_cnt > 0) begin
      if (main_mem_addr_reg !== addr_q) begin
        addr_moves <= addr_moves + 1;
      end
      wait_cnt <= wait_cnt - 1;
    end
  end
  // Data toggles until access completes, so a too-early sample never looks valid
  always @(posedge clk) begin
    if (wait_cnt > 1) begin
      mem_rd_data <= ~mem_rd_data;
    end else if (wait_cnt == 1) begin
      mem_rd_data <= mem_arr[addr_q[5:0]];
    end
  end
endmodule

// File: csq_pkg.sv
// Types shared by the control sequencer
package csq_pkg;
  typedef enum logic [3:0] {
    SEQ_IDLE, SEQ_FETCH, SEQ_OPREAD, SEQ_OPREAD2, SEQ_WRITE,
    SEQ_INTR, SEQ_TERM, SEQ_INIT, SEQ_IO1, SEQ_IO2, SEQ_WAIT
  } csq_seq_t;
  typedef enum logic [2:0] {
    CL_COUNT, CL_READ, CL_READ2, CL_DBL, CL_WRITE, CL_BSTEP, CL_JUMP, CL_SPECIAL
  } csq_class_t;
endpackage

// File: csq_sequencer.sv
// Control sequencer with index, page, address and count registers
`timescale 1ns/1ps
`include "csq_consts.svh"
module csq_sequencer #(
  parameter int PHASE_CYC = `CSQ_PHASE_CYC
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        arst_n,
  // Run control and requests
  input  wire logic        run,
  input  wire logic        intr_req,
  input  wire logic        buf_req,
  input  wire logic [2:0]  buf_chan,
  input  wire logic        io_req,
  input  wire logic        io_dbl,
  input  wire logic        io_write,
  input  wire logic [15:0] io_addr,
  // Memory read data and arithmetic status
  input  wire logic [17:0] mem_rd_data,
  input  wire logic [17:0] adder_in,
  input  wire logic        parity_clr,
  input  wire logic        acc_zero,
  input  wire logic        acc_neg,
  input  wire logic        add_sign_a,
  input  wire logic        add_sign_b,
  input  wire logic        add_sign_r,
  input  wire logic        add_step,
  // Memory address side
  output logic [15:0]      main_mem_addr_reg,
  output logic [7:0]       ctl_mem_addr_reg,
  output logic             mem_start_reg,
  output logic             ctl_mem_sel_reg,
  output logic             mem_write_reg,
  // Timing and sequence state
  output logic [1:0]       phase_reg,
  output logic [1:0]       clk_cycle_reg,
  output logic [3:0]       seq_code_reg,
  // Registers and enables
  output logic [15:0]      pc_reg,
  output logic [2:0]       index_select_reg,
  output logic [4:0]       page_extension_reg,
  output logic [5:0]       count_reg,
  output logic [15:0]      b_hold_reg,
  output logic             xfer_en_reg,
  output logic             shift_en_reg,
  output logic             parity_err_reg,
  output logic             jump_en_reg,
  output logic             ovf_reg
);
  if (PHASE_CYC < 1 || PHASE_CYC > 65536) begin : g_phase_check
    $error("PHASE_CYC must lie in 1 to 65536");
  end

  function automatic csq_pkg::csq_class_t fn_class(input logic [5:0] f);
    csq_pkg::csq_class_t c;
    c = csq_pkg::csq_class_t'(f[5:3]);
    return c;
  endfunction

  function automatic logic fn_indexed(input logic [5:0] f);
    return f[0] && f >= `CSQ_FN_IDX_LO && f <= `CSQ_FN_IDX_HI;
  endfunction

  // Phase divider and timing chain
  logic [15:0] div_reg;
  logic        tick;
  logic        cc_end;
  assign tick   = div_reg == 16'(PHASE_CYC - 1);
  assign cc_end = tick && phase_reg == 2'h3 && clk_cycle_reg == 2'h3;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      div_reg       <= 16'h0000;
      phase_reg     <= 2'h0;
      clk_cycle_reg <= 2'h0;
    end else begin
      div_reg <= tick ? 16'h0000 : div_reg + 16'h0001;
      if (tick) begin
        phase_reg <= phase_reg + 2'h1;
        if (phase_reg == 2'h3) clk_cycle_reg <= clk_cycle_reg + 2'h1;
      end
    end
  end

  // Instruction and operand address
  csq_pkg::csq_seq_t seq_reg;
  csq_pkg::csq_seq_t seq_next;
  csq_pkg::csq_seq_t resume_reg;
  csq_pkg::csq_seq_t resume_next;
  logic [17:0] instr_reg;
  logic [17:0] instr_src;
  logic [15:0] idx_mem [8];
  logic [5:0]  k_lower_reg;
  logic        k_busy_reg;
  logic        io_dbl_reg;
  logic        io_write_reg;
  logic [15:0] io_addr_reg;
  logic [2:0]  chan_reg;
  logic [5:0]  fn;
  logic [11:0] eff_low;
  logic [3:0]  page_bits;
  logic [15:0] eff_addr;
  csq_pkg::csq_class_t cls;

  // Fetched word is decoded at the very boundary that ends its fetch
  assign instr_src = cc_end && seq_reg == csq_pkg::SEQ_FETCH ? mem_rd_data : instr_reg;
  assign fn        = instr_src[17:12];
  assign cls       = fn_class(fn);
  assign eff_low   = fn_indexed(fn) ? instr_src[11:0] + b_hold_reg[11:0] : instr_src[11:0];
  assign page_bits = count_reg[`CSQ_K_PAGE_BIT] ? page_extension_reg[3:0] : pc_reg[15:12];
  assign eff_addr  = {page_bits, eff_low};

  // Pending control sequence, decided as the current one ends
  always_comb begin
    case (seq_reg)
      csq_pkg::SEQ_FETCH: begin
        case (fn_class(mem_rd_data[17:12]))
          csq_pkg::CL_READ, csq_pkg::CL_READ2, csq_pkg::CL_DBL: resume_next = csq_pkg::SEQ_OPREAD;
          csq_pkg::CL_WRITE: resume_next = csq_pkg::SEQ_WRITE;
          default: resume_next = mem_rd_data[17:12] == `CSQ_FN_WAIT ? csq_pkg::SEQ_WAIT : csq_pkg::SEQ_FETCH;
        endcase
      end
      csq_pkg::SEQ_OPREAD: resume_next = cls == csq_pkg::CL_DBL ? csq_pkg::SEQ_OPREAD2 : csq_pkg::SEQ_FETCH;
      csq_pkg::SEQ_OPREAD2, csq_pkg::SEQ_WRITE: resume_next = csq_pkg::SEQ_FETCH;
      csq_pkg::SEQ_INTR: resume_next = resume_reg == csq_pkg::SEQ_WAIT ? csq_pkg::SEQ_FETCH : resume_reg;
      default: resume_next = resume_reg;
    endcase
  end

  // Next major sequence, I/O ahead of control
  always_comb begin
    if (seq_reg == csq_pkg::SEQ_TERM) seq_next = csq_pkg::SEQ_INIT;
    else if (seq_reg == csq_pkg::SEQ_IO1 && io_dbl_reg) seq_next = csq_pkg::SEQ_IO2;
    else if (intr_req) seq_next = csq_pkg::SEQ_INTR;
    else if (buf_req) seq_next = csq_pkg::SEQ_TERM;
    else if (io_req) seq_next = csq_pkg::SEQ_IO1;
    else if (resume_next == csq_pkg::SEQ_WAIT) seq_next = csq_pkg::SEQ_WAIT;
    else if (run && !k_busy_reg) seq_next = resume_next;
    else seq_next = csq_pkg::SEQ_IDLE;
  end

  // Major sequencer
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      seq_reg      <= csq_pkg::SEQ_IDLE;
      resume_reg   <= csq_pkg::SEQ_FETCH;
      seq_code_reg <= 4'h0;
    end else if (cc_end) begin
      seq_reg      <= seq_next;
      seq_code_reg <= 4'(seq_next);
      resume_reg   <= resume_next;
    end
  end

  // I/O request capture at the boundary
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      io_dbl_reg   <= 1'b0;
      io_write_reg <= 1'b0;
      io_addr_reg  <= 16'h0000;
      chan_reg     <= 3'h0;
    end else if (cc_end && seq_next == csq_pkg::SEQ_IO1) begin
      io_dbl_reg   <= io_dbl;
      io_write_reg <= io_write;
      io_addr_reg  <= io_addr;
    end else if (cc_end && seq_next == csq_pkg::SEQ_TERM) begin
      chan_reg <= buf_chan;
    end
  end

  // Memory address registers, loaded once per memory cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      main_mem_addr_reg <= 16'h0000;
      ctl_mem_addr_reg  <= 8'h00;
      mem_start_reg     <= 1'b0;
      ctl_mem_sel_reg   <= 1'b0;
      mem_write_reg     <= 1'b0;
    end else begin
      mem_start_reg <= cc_end && seq_next != csq_pkg::SEQ_IDLE && seq_next != csq_pkg::SEQ_WAIT;
      if (cc_end) begin
        ctl_mem_sel_reg <= 1'b0;
        mem_write_reg   <= 1'b0;
        case (seq_next)
          csq_pkg::SEQ_FETCH: main_mem_addr_reg <= seq_reg == csq_pkg::SEQ_FETCH ? pc_reg + 16'h0001 : pc_reg;
          csq_pkg::SEQ_OPREAD: main_mem_addr_reg <= eff_addr;
          csq_pkg::SEQ_OPREAD2: main_mem_addr_reg <= eff_addr + 16'h0001;
          csq_pkg::SEQ_WRITE: begin
            main_mem_addr_reg <= eff_addr;
            mem_write_reg     <= 1'b1;
          end
          csq_pkg::SEQ_INTR: begin
            ctl_mem_addr_reg <= `CSQ_CTL_INTR_ADDR;
            ctl_mem_sel_reg  <= 1'b1;
          end
          csq_pkg::SEQ_TERM: begin
            ctl_mem_addr_reg <= `CSQ_CTL_BUF_BASE + {4'h0, buf_chan, 1'b0};
            ctl_mem_sel_reg  <= 1'b1;
            mem_write_reg    <= 1'b1;
          end
          csq_pkg::SEQ_INIT: begin
            ctl_mem_addr_reg <= `CSQ_CTL_BUF_BASE + {4'h0, chan_reg, 1'b1};
            ctl_mem_sel_reg  <= 1'b1;
            mem_write_reg    <= 1'b1;
          end
          csq_pkg::SEQ_IO1: begin
            main_mem_addr_reg <= io_addr;
            mem_write_reg     <= io_write;
          end
          csq_pkg::SEQ_IO2: begin
            main_mem_addr_reg <= io_addr_reg + 16'h0001;
            mem_write_reg     <= io_write_reg;
          end
          default: main_mem_addr_reg <= main_mem_addr_reg;
        endcase
      end
    end
  end

  // Instruction register, counter, program-loaded registers
  logic fetch_done;
  assign fetch_done = cc_end && seq_reg == csq_pkg::SEQ_FETCH;

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      instr_reg          <= 18'h00000;
      pc_reg             <= 16'h0000;
      index_select_reg   <= 3'h0;
      page_extension_reg <= 5'h00;
    end else if (fetch_done) begin
      instr_reg <= mem_rd_data;
      pc_reg    <= pc_reg + 16'h0001;
      if (mem_rd_data[17:12] == `CSQ_FN_LD_SEL) index_select_reg <= mem_rd_data[2:0];
      if (mem_rd_data[17:12] == `CSQ_FN_LD_PAGE) page_extension_reg <= mem_rd_data[4:0];
    end
  end

  // Index locations and holding register with step network
  logic [17:12] fd;
  assign fd = mem_rd_data[17:12];

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < 8; i++) idx_mem[i] <= 16'h0000;
      b_hold_reg <= 16'h0000;
    end else begin
      if (fetch_done && fd == `CSQ_FN_LD_IDX) idx_mem[index_select_reg] <= {4'h0, mem_rd_data[11:0]};
      else if (fetch_done && fn_class(fd) == csq_pkg::CL_BSTEP && b_hold_reg != 16'h0000)
        idx_mem[index_select_reg] <= b_hold_reg - 16'h0001;
      b_hold_reg <= idx_mem[index_select_reg];
    end
  end

  // Count register: two ranks stepped by the shift minor sequence
  logic k_rank_reg;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      count_reg    <= 6'h00;
      k_lower_reg  <= 6'h00;
      k_busy_reg   <= 1'b0;
      k_rank_reg   <= 1'b0;
      shift_en_reg <= 1'b0;
    end else begin
      shift_en_reg <= 1'b0;
      if (fetch_done && (fn_class(fd) == csq_pkg::CL_COUNT || fd == `CSQ_FN_LD_SKIP)) begin
        count_reg  <= mem_rd_data[5:0];
        k_busy_reg <= fn_class(fd) == csq_pkg::CL_COUNT && mem_rd_data[5:0] != 6'h00;
        k_rank_reg <= 1'b0;
      end else if (k_busy_reg && tick) begin
        if (!k_rank_reg) begin
          k_lower_reg  <= count_reg - 6'h01;
          shift_en_reg <= 1'b1;
        end else begin
          count_reg <= k_lower_reg;
          if (k_lower_reg == 6'h00) k_busy_reg <= 1'b0;
        end
        k_rank_reg <= !k_rank_reg;
      end
    end
  end

  // Transfer enable from sequencer state
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) xfer_en_reg <= 1'b0;
    else xfer_en_reg <= tick && phase_reg == 2'h3 && clk_cycle_reg == 2'h2 &&
                        seq_reg != csq_pkg::SEQ_IDLE && seq_reg != csq_pkg::SEQ_WAIT;
  end

  // Parity, compare and overflow; a set beats a same-cycle clear
  logic par_even;
  assign par_even = ~^adder_in;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      parity_err_reg <= 1'b0;
      jump_en_reg    <= 1'b0;
      ovf_reg        <= 1'b0;
    end else begin
      if (add_step && par_even) parity_err_reg <= 1'b1;
      else if (parity_clr) parity_err_reg <= 1'b0;
      if (fetch_done)
        case (fn_class(fd))
          csq_pkg::CL_JUMP: jump_en_reg <= mem_rd_data[0] ? acc_neg : acc_zero;
          csq_pkg::CL_BSTEP: jump_en_reg <= b_hold_reg != 16'h0000;
          default: jump_en_reg <= 1'b0;
        endcase
      if (add_step) ovf_reg <= add_sign_a == add_sign_b && add_sign_r != add_sign_a;
    end
  end

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  a_pc_fetch_step: assert property (fetch_done |=> pc_reg == $past(pc_reg) + 16'h0001)
    else $error("counter did not step on fetch");
  a_addr_hold_cycle: assert property (!cc_end |=> $stable(main_mem_addr_reg))
    else $error("main address moved inside a cycle");
  a_wait_blocks_ctl: assert property (cc_end && resume_next == csq_pkg::SEQ_WAIT |=>
    seq_reg inside {csq_pkg::SEQ_WAIT, csq_pkg::SEQ_INTR, csq_pkg::SEQ_TERM, csq_pkg::SEQ_IO1,
                    csq_pkg::SEQ_INIT, csq_pkg::SEQ_IO2})
    else $error("control sequence ran during wait");
  a_term_then_init: assert property (cc_end && seq_reg == csq_pkg::SEQ_TERM |=> seq_reg == csq_pkg::SEQ_INIT)
    else $error("buffer sequences out of order");
  a_io_second_half: assert property (cc_end && seq_reg == csq_pkg::SEQ_IO1 && io_dbl_reg |=>
    seq_reg == csq_pkg::SEQ_IO2 ##0 main_mem_addr_reg == io_addr_reg + 16'h0001)
    else $error("second I/O half missing");
  a_page_select: assert property (cc_end && seq_next == csq_pkg::SEQ_OPREAD |=>
    main_mem_addr_reg[15:12] == ($past(count_reg[3]) ? $past(page_extension_reg[3:0]) : $past(pc_reg[15:12])))
    else $error("wrong upper address source");
  a_parity_sets: assert property (add_step && par_even |=> parity_err_reg)
    else $error("even parity not flagged");
  a_ovf_report: assert property (add_step && add_sign_a == add_sign_b && add_sign_r != add_sign_a |=> ovf_reg)
    else $error("overflow not reported");
  a_count_down: assert property (k_busy_reg && tick && !k_rank_reg |=> k_lower_reg == $past(count_reg) - 6'h01)
    else $error("count rank transfer did not decrement");
  a_phase_wrap: assert property (tick && phase_reg == 2'h3 |=> phase_reg == 2'h0)
    else $error("phase did not wrap");

  c_double_read: cover property (cc_end && seq_reg == csq_pkg::SEQ_OPREAD2);
  c_wait_to_intr: cover property (cc_end && resume_reg == csq_pkg::SEQ_WAIT && seq_next == csq_pkg::SEQ_INTR);
  c_shift_done: cover property (k_busy_reg ##1 !k_busy_reg);
  c_io_double: cover property (seq_reg == csq_pkg::SEQ_IO2);
endmodule
